// *** hdl/ssx_setup_exc.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Out-of-range data value gets exception code 03.
// - Three seconds of calibration after any reset; requests then answer busy 06.
// - Setup byte one is the text address only, from 21 hex; binary address separate.
// - Byte two bit 7 appends linefeed in text mode; binary ignores it.
// - Byte two bits 6:5 pick parity: 00/10 none, 01 even, 11 odd.
// - Text mode always frames 1 start, 7 data, parity as set in byte two (may be none), 1 stop.
// - Byte two low nibble selects baud from 300 to 115200.
// - Byte three bits 1:0 add 0/2/4/6 character delays, text mode only.
// - Byte four bits 7:6 pick displayed digits, text mode only.
// - Byte four two filter fields: off or 0.25 to 16 seconds, both protocols.
// - Zero trim is applied digitally after conversion.
// - Binary readings above full scale saturate FFFF; 0000 stays negative overload.
// - Unknown function code gets exception code 01.
// - Unsupported data address gets exception code 02.
module ssx_setup_exc #(
    parameter int CAL_CYCLES = ssx_pkg::CAL_CYCLES
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Text-protocol commands
    input wire logic setup_write_command_in,
    input wire logic [7:0] setup_byte1_in,
    input wire logic [7:0] setup_byte2_in,
    input wire logic [7:0] setup_byte3_in,
    input wire logic [7:0] setup_byte4_in,
    input wire logic binary_protocol_address_enable_command_in,
    input wire logic [7:0] binary_address_in,
    input wire logic remote_restart_command_in,
    input wire logic fallback_in,
    input wire logic zero_trim_command_in,
    input wire logic signed [17:0] zero_trim_value_in,
    // Binary request, already checked by the function handler
    input wire logic req_valid_in,
    input wire logic [7:0] req_addr_in,
    input wire logic [7:0] req_func_in,
    input wire logic func_known_in,
    input wire logic addr_ok_in,
    input wire logic value_ok_in,
    // Conversion data
    input wire logic sample_valid_in,
    input wire logic signed [17:0] sample_in,
    // Exception reply, one byte per cycle
    output logic exc_valid_out,
    output logic [7:0] exc_byte_out,
    output logic exc_last_out,
    output logic req_pass_out,
    // Decoded settings
    output logic [7:0] text_channel_address_out,
    output logic text_address_valid_out,
    output logic [7:0] binary_address_out,
    output logic text_mode_out,
    output logic calibrating_out,
    output logic [1:0] parity_out,
    output logic [3:0] data_bits_out,
    output logic [31:0] baud_out,
    output logic linefeed_out,
    output logic [2:0] delay_chars_out,
    output logic [1:0] digits_out,
    output logic [15:0] large_tc_ms_out,
    output logic [15:0] small_tc_ms_out,
    output logic [15:0] reading_out
);
    ssx_cfg_if cfg();
    ssx_pkg::ssx_state_t state;
    ssx_pkg::ssx_state_t next_state;
    logic [7:0] text_channel_address;
    logic [7:0] line_parity_baud_setup;
    logic [7:0] option_delay_setup;
    logic [7:0] digits_filter_setup;
    logic [7:0] binary_address;
    logic binary_enabled;
    logic signed [17:0] zero_trim;
    logic [31:0] cal_count;
    logic fallback_d;
    logic restart_evt;
    logic cal_done;
    logic [7:0] exc_code;
    logic [7:0] exc_addr;
    logic [7:0] exc_func;
    logic [2:0] exc_idx;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [7:0] next_byte;
    logic need_exc;
    logic [7:0] next_code;

    assign cfg.line_setup = line_parity_baud_setup;
    assign cfg.option_setup = option_delay_setup;
    assign cfg.filter_setup = digits_filter_setup;
    assign cfg.text_mode = text_mode_out;

    ssx_decode u_decode (
        .cfg(cfg)
    );

    ssx_scale u_scale (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .sample_valid_in(sample_valid_in),
        .sample_in(sample_in),
        .zero_trim_in(zero_trim),
        .reading_out(reading_out)
    );

    // Setup registers; binary address is held apart from the text address
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            text_channel_address <= ssx_pkg::RST_TEXT_ADDR;
            line_parity_baud_setup <= ssx_pkg::RST_LINE_SETUP;
            option_delay_setup <= ssx_pkg::RST_OPTION_SETUP;
            digits_filter_setup <= ssx_pkg::RST_FILTER_SETUP;
        end else if (setup_write_command_in) begin
            text_channel_address <= setup_byte1_in;
            line_parity_baud_setup <= setup_byte2_in;
            option_delay_setup <= setup_byte3_in;
            digits_filter_setup <= setup_byte4_in;
        end
    end

    // Enabling takes effect only at the next restart
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            binary_address <= ssx_pkg::RST_BIN_ADDR;
            binary_enabled <= 1'b0;
        end else if (binary_protocol_address_enable_command_in) begin
            binary_address <= binary_address_in;
            binary_enabled <= 1'b1;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            zero_trim <= 18'sh0;
        end else if (zero_trim_command_in) begin
            zero_trim <= zero_trim_value_in;
        end
    end

    // Calibration sequencing
    assign restart_evt = remote_restart_command_in | (fallback_d & ~fallback_in);
    assign cal_done = (cal_count >= 32'(CAL_CYCLES - 1));

    always_comb begin
        case (state)
            ssx_pkg::SSX_IDLE: next_state = ssx_pkg::SSX_CALIB;
            ssx_pkg::SSX_CALIB: next_state = cal_done ? ssx_pkg::SSX_READY : ssx_pkg::SSX_CALIB;
            ssx_pkg::SSX_READY: next_state = fallback_in ? ssx_pkg::SSX_FALLBACK : ssx_pkg::SSX_READY;
            ssx_pkg::SSX_FALLBACK: next_state = fallback_in ? ssx_pkg::SSX_FALLBACK : ssx_pkg::SSX_IDLE;
            default: next_state = ssx_pkg::SSX_IDLE;
        endcase
        if (remote_restart_command_in) begin
            next_state = ssx_pkg::SSX_CALIB;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ssx_pkg::SSX_IDLE;
            fallback_d <= 1'b0;
            cal_count <= 32'h0;
            text_mode_out <= 1'b1;
        end else begin
            state <= next_state;
            fallback_d <= fallback_in;
            if (restart_evt || state != ssx_pkg::SSX_CALIB) begin
                cal_count <= 32'h0;
            end else begin
                cal_count <= cal_count + 32'h1;
            end
            if (next_state == ssx_pkg::SSX_FALLBACK) begin
                text_mode_out <= 1'b1;
            end else if (state == ssx_pkg::SSX_IDLE || restart_evt) begin
                text_mode_out <= ~binary_enabled;
            end
        end
    end

    assign calibrating_out = (state != ssx_pkg::SSX_READY) && (state != ssx_pkg::SSX_FALLBACK);

    // Exception priority: busy, function, address, value
    assign next_code = calibrating_out ? ssx_pkg::EXC_BUSY :
        !func_known_in ? ssx_pkg::EXC_ILLEGAL_FUNCTION :
        !addr_ok_in ? ssx_pkg::EXC_ILLEGAL_ADDRESS :
        ssx_pkg::EXC_ILLEGAL_VALUE;
    assign need_exc = req_valid_in && !text_mode_out && !exc_valid_out &&
        (calibrating_out || !func_known_in || !addr_ok_in || !value_ok_in);
    assign req_pass_out = req_valid_in && !text_mode_out && !exc_valid_out && !need_exc;

    // Reply bytes: address, flagged function, code, CRC low, CRC high
    always_comb begin
        case (exc_idx)
            3'h0: next_byte = exc_addr;
            3'h1: next_byte = exc_func | ssx_pkg::EXC_FUNC_FLAG;
            3'h2: next_byte = exc_code;
            3'h3: next_byte = crc[7:0];
            default: next_byte = crc[15:8];
        endcase
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        crc_step = r;
    endfunction : crc_step

    assign next_crc = crc_step(crc, next_byte);

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            exc_valid_out <= 1'b0;
            exc_byte_out <= 8'h00;
            exc_last_out <= 1'b0;
            exc_idx <= 3'h0;
            exc_addr <= 8'h00;
            exc_func <= 8'h00;
            exc_code <= 8'h00;
            crc <= 16'hffff;
        end else if (need_exc) begin
            exc_addr <= req_addr_in;
            exc_func <= req_func_in;
            exc_code <= next_code;
            exc_idx <= 3'h0;
            crc <= 16'hffff;
            exc_valid_out <= 1'b1;
            exc_last_out <= 1'b0;
        end else if (exc_valid_out) begin
            exc_byte_out <= next_byte;
            exc_last_out <= (exc_idx == 3'h4);
            if (exc_idx < 3'h3) begin
                crc <= next_crc;
            end
            if (exc_idx == 3'h5) begin
                exc_valid_out <= 1'b0;
                exc_last_out <= 1'b0;
            end
            exc_idx <= exc_idx + 3'h1;
        end
    end

    assign text_channel_address_out = text_channel_address;
    assign text_address_valid_out = (text_channel_address >= ssx_pkg::TEXT_ADDR_MIN) &&
        (text_channel_address <= ssx_pkg::TEXT_ADDR_MAX);
    assign binary_address_out = binary_address;
    assign parity_out = cfg.parity;
    assign data_bits_out = cfg.data_bits;
    assign baud_out = cfg.baud;
    assign linefeed_out = cfg.linefeed;
    assign delay_chars_out = cfg.delay_chars;
    assign digits_out = cfg.digits;
    assign large_tc_ms_out = cfg.large_tc_ms;
    assign small_tc_ms_out = cfg.small_tc_ms;
endmodule : ssx_setup_exc

// *** hdl/ssx_pkg.sv ***
package ssx_pkg;
    // Exception codes
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY = 8'h06;
    localparam logic [7:0] EXC_FUNC_FLAG = 8'h80;
    // Setup byte fields
    localparam int LINEFEED_BIT = 7;
    localparam int PARITY_HI = 6;
    localparam int PARITY_LO = 5;
    localparam int BAUD_HI = 3;
    localparam int DELAY_HI = 1;
    localparam int DIGITS_HI = 7;
    localparam int DIGITS_LO = 6;
    localparam int LARGE_HI = 5;
    localparam int LARGE_LO = 3;
    localparam int SMALL_HI = 2;
    localparam logic [7:0] TEXT_ADDR_MIN = 8'h21;
    localparam logic [7:0] TEXT_ADDR_MAX = 8'h7e;
    // Reset values
    localparam logic [7:0] RST_TEXT_ADDR = 8'h31;
    localparam logic [7:0] RST_LINE_SETUP = 8'h07;
    localparam logic [7:0] RST_OPTION_SETUP = 8'h00;
    localparam logic [7:0] RST_FILTER_SETUP = 8'h00;
    localparam logic [7:0] RST_BIN_ADDR = 8'h01;
    // Parity selections
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    // Framing
    localparam logic [3:0] TEXT_DATA_BITS = 4'h7;
    localparam logic [3:0] BIN_DATA_BITS = 4'h8;
    // Readings
    localparam logic [15:0] READ_POS_OVERLOAD = 16'hffff;
    localparam logic [15:0] READ_NEG_OVERLOAD = 16'h0000;
    localparam logic [15:0] READ_POS_FULL = 16'hfffe;
    localparam logic [15:0] READ_NEG_FULL = 16'h0001;
    // Timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int CAL_TIME_MS = 3000;
    localparam int CAL_CYCLES = CAL_TIME_MS * (CLOCK_HZ / 1000);
    localparam int FILTER_BASE_MS = 250;
    localparam int BAUD_COUNT = 10;
    typedef enum logic [3:0] {
        SSX_IDLE = 4'b0001,
        SSX_CALIB = 4'b0010,
        SSX_READY = 4'b0100,
        SSX_FALLBACK = 4'b1000
    } ssx_state_t;
endpackage : ssx_pkg

// *** hdl/ssx_cfg_if.sv ***
`timescale 1ns/1ps
interface ssx_cfg_if;
    logic [7:0] line_setup;
    logic [7:0] option_setup;
    logic [7:0] filter_setup;
    logic text_mode;
    logic [1:0] parity;
    logic [3:0] data_bits;
    logic [31:0] baud;
    logic linefeed;
    logic [2:0] delay_chars;
    logic [1:0] digits;
    logic [15:0] large_tc_ms;
    logic [15:0] small_tc_ms;
    modport src (output line_setup, output option_setup, output filter_setup, output text_mode);
    modport dec (input line_setup, input option_setup, input filter_setup, input text_mode,
        output parity, output data_bits, output baud, output linefeed, output delay_chars,
        output digits, output large_tc_ms, output small_tc_ms);
endinterface : ssx_cfg_if

// *** hdl/ssx_decode.sv ***
`timescale 1ns/1ps
module ssx_decode (
    // Setup bytes in, decoded settings out
    ssx_cfg_if.dec cfg
);
    logic [3:0] baud_code;
    logic [2:0] large_code;
    logic [2:0] small_code;
    assign baud_code = cfg.line_setup[ssx_pkg::BAUD_HI:0];
    assign large_code = cfg.filter_setup[ssx_pkg::LARGE_HI:ssx_pkg::LARGE_LO];
    assign small_code = cfg.filter_setup[ssx_pkg::SMALL_HI:0];

    function automatic logic [15:0] tc_ms(input logic [2:0] code);
        logic [15:0] base;
        base = 16'(ssx_pkg::FILTER_BASE_MS);
        tc_ms = (code == 3'h0) ? 16'h0000 : 16'(base << (code - 3'h1));
    endfunction : tc_ms

    // Codes 00 and 10 are both no parity
    assign cfg.parity = (cfg.line_setup[ssx_pkg::PARITY_LO] == 1'b0) ? ssx_pkg::PAR_NONE :
        (cfg.line_setup[ssx_pkg::PARITY_HI] ? ssx_pkg::PAR_ODD : ssx_pkg::PAR_EVEN);
    assign cfg.data_bits = cfg.text_mode ? ssx_pkg::TEXT_DATA_BITS : ssx_pkg::BIN_DATA_BITS;
    assign cfg.linefeed = cfg.text_mode & cfg.line_setup[ssx_pkg::LINEFEED_BIT];
    assign cfg.delay_chars = cfg.text_mode ? {cfg.option_setup[ssx_pkg::DELAY_HI:0], 1'b0} : 3'h0;
    assign cfg.digits = cfg.text_mode ? cfg.filter_setup[ssx_pkg::DIGITS_HI:ssx_pkg::DIGITS_LO] : 2'h0;
    assign cfg.large_tc_ms = tc_ms(large_code);
    assign cfg.small_tc_ms = tc_ms(small_code);

    // Unlisted codes fall back to the slowest rate
    always_comb begin
        case (baud_code)
            4'h7: cfg.baud = 32'd300;
            4'h6: cfg.baud = 32'd600;
            4'h5: cfg.baud = 32'd1200;
            4'h4: cfg.baud = 32'd2400;
            4'h3: cfg.baud = 32'd4800;
            4'h2: cfg.baud = 32'd9600;
            4'h1: cfg.baud = 32'd19200;
            4'h0: cfg.baud = 32'd38400;
            4'h9: cfg.baud = 32'd57600;
            4'h8: cfg.baud = 32'd115200;
            default: cfg.baud = 32'd300;
        endcase
    end
endmodule : ssx_decode

// *** hdl/ssx_scale.sv ***
`timescale 1ns/1ps
module ssx_scale (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Conversion in
    input wire logic sample_valid_in,
    input wire logic signed [17:0] sample_in,
    input wire logic signed [17:0] zero_trim_in,
    // Reading out
    output logic [15:0] reading_out
);
    // Trim applied digitally after conversion; full scale maps to 0001..fffe around 8000
    logic signed [18:0] trimmed;
    logic signed [18:0] pos_lim;
    logic signed [18:0] neg_lim;
    logic [15:0] next_reading;
    assign trimmed = 19'(sample_in) + 19'(zero_trim_in);
    assign pos_lim = 19'sd32766;
    assign neg_lim = -19'sd32767;
    assign next_reading = (trimmed > pos_lim) ? ssx_pkg::READ_POS_OVERLOAD :
        (trimmed < neg_lim) ? ssx_pkg::READ_NEG_OVERLOAD :
        16'(trimmed + 19'sd32768);
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reading_out <= 16'h8000;
        end else if (sample_valid_in) begin
            reading_out <= next_reading;
        end
    end
endmodule : ssx_scale

// *** verification/ssx_setup_exc_monitor.sv ***
`timescale 1ns/1ps
module ssx_setup_exc_monitor (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Requests and commands
    input wire logic req_valid_in,
    input wire logic [7:0] req_addr_in,
    input wire logic [7:0] req_func_in,
    input wire logic func_known_in,
    input wire logic addr_ok_in,
    input wire logic value_ok_in,
    input wire logic remote_restart_command_in,
    // Reply and status
    input wire logic exc_valid_out,
    input wire logic [7:0] exc_byte_out,
    input wire logic exc_last_out,
    input wire logic req_pass_out,
    input wire logic text_mode_out,
    input wire logic calibrating_out,
    input wire logic [3:0] data_bits_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire logic taken = req_valid_in && !text_mode_out && !exc_valid_out;
    wire logic refused = taken && !req_pass_out;
    wire logic judged = taken && !calibrating_out;
    AST_TAKE: assert property (refused |=> exc_valid_out)
        else $error("reply did not start");
    AST_REPLY_LEN: assert property ($rose(exc_valid_out) |-> exc_valid_out [*6] ##1 !exc_valid_out)
        else $error("reply length wrong");
    AST_ECHO: assert property (refused |-> ##2 exc_byte_out == $past(req_addr_in, 2))
        else $error("address not echoed");
    AST_FUNC: assert property (refused |-> ##3 exc_byte_out == ($past(req_func_in, 3) | 8'h80))
        else $error("function flag missing");
    AST_LAST: assert property ($rose(exc_valid_out) |-> !exc_last_out [*5] ##1 exc_last_out)
        else $error("last byte marker misplaced");
    AST_BUSY: assert property (taken && calibrating_out |-> ##4 exc_byte_out == ssx_pkg::EXC_BUSY)
        else $error("busy code missing");
    AST_ILL_FUNC: assert property (judged && !func_known_in |-> ##4 exc_byte_out == 8'h01)
        else $error("illegal function code wrong");
    AST_ILL_ADDR: assert property (judged && func_known_in && !addr_ok_in |-> ##4 exc_byte_out == 8'h02)
        else $error("illegal address code wrong");
    AST_ILL_VALUE: assert property (judged && func_known_in && addr_ok_in && !value_ok_in
        |-> ##4 exc_byte_out == 8'h03)
        else $error("illegal value code wrong");
    AST_PASS: assert property (req_pass_out && !exc_valid_out
        |-> !calibrating_out && func_known_in && addr_ok_in && value_ok_in ##1 !exc_valid_out)
        else $error("pass granted wrongly");
    AST_RESTART: assert property (remote_restart_command_in |=> calibrating_out)
        else $error("restart did not calibrate");
    AST_FRAME: assert property (text_mode_out |-> data_bits_out == ssx_pkg::TEXT_DATA_BITS)
        else $error("text framing not seven bits");
endmodule : ssx_setup_exc_monitor
bind ssx_setup_exc ssx_setup_exc_monitor u_ssx_setup_exc_monitor (.*);

// *** verification/ssx_host_model.sv ***
`timescale 1ns/1ps
module ssx_host_model (
    // Clock
    input wire logic clock_in,
    // Reply from the block
    input wire logic exc_valid_in,
    input wire logic [7:0] exc_byte_in,
    input wire logic req_pass_in,
    // Request to the block
    output logic req_valid_out,
    output logic [7:0] req_addr_out,
    output logic [7:0] req_func_out,
    output logic [2:0] checks_out
);
    logic [7:0] resp [0:4];
    logic pass_seen;
    logic exc_seen = 1'b0;
    int n = 0;
    initial begin
        req_valid_out = 1'b0;
        {req_addr_out, req_func_out, checks_out} = '0;
    end
    // First reply cycle is a prefetch, bytes follow
    always @(posedge clock_in) begin
        if (!exc_valid_in) begin
            n <= 0;
        end else begin
            if (n > 0 && n < 6) resp[n - 1] <= exc_byte_in;
            n <= n + 1;
            exc_seen <= 1'b1;
        end
    end
    task automatic send(input logic [7:0] a, input logic [7:0] f, input logic [2:0] ok);
        exc_seen = 1'b0;
        req_addr_out = a;
        req_func_out = f;
        checks_out = ok;
        req_valid_out = 1'b1;
        #4;
        pass_seen = req_pass_in;
        @(negedge clock_in);
        req_valid_out = 1'b0;
        // Released lines show no stale request
        req_addr_out = ~a;
        req_func_out = ~f;
        checks_out = ~ok;
        repeat (9) @(negedge clock_in);
    endtask : send
endmodule : ssx_host_model

// *** verification/serial_setup_exception_logic_tb_top.sv ***
`timescale 1ns/1ps
module serial_setup_exception_logic_tb_top;
    logic clock_in, sys_rst_in, setup_write_command_in, binary_protocol_address_enable_command_in;
    logic remote_restart_command_in, fallback_in, zero_trim_command_in, sample_valid_in, req_valid_in;
    logic [7:0] setup_byte1_in, setup_byte2_in, setup_byte3_in, setup_byte4_in, binary_address_in;
    logic signed [17:0] zero_trim_value_in, sample_in;
    logic [7:0] req_addr_in, req_func_in, exc_byte_out, text_channel_address_out, binary_address_out, b1;
    logic func_known_in, addr_ok_in, value_ok_in, exc_valid_out, exc_last_out, req_pass_out;
    logic text_address_valid_out, text_mode_out, calibrating_out, linefeed_out;
    logic [1:0] parity_out, digits_out, p;
    logic [2:0] delay_chars_out, c3;
    logic [3:0] data_bits_out;
    logic [2:0] checks;
    logic [31:0] baud_out;
    logic [15:0] large_tc_ms_out, small_tc_ms_out, reading_out;
    int errors = 0;
    int tests_run = 0;
    int n;
    logic [3:0] baud_code [10] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h9, 4'h8};
    logic [31:0] baud_rate [10] = '{32'h12c, 32'h258, 32'h4b0, 32'h960, 32'h12c0, 32'h2580, 32'h4b00,
        32'h9600, 32'he100, 32'h1c200};
    logic [2:0] oks [4] = '{3'h3, 3'h5, 3'h6, 3'h0};
    logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
    logic signed [17:0] trims [5] = '{18'sh0, 18'sh0, 18'sh0, 18'sh1000, 18'sh1000};
    logic signed [17:0] samples [5] = '{18'sh7ffe, -18'sh8000, -18'sh7fff, -18'sh7ffe, 18'sh7530};
    ssx_setup_exc #(.CAL_CYCLES(20)) u_ssx_setup_exc (.*);
    ssx_host_model u_ssx_host_model (.clock_in(clock_in), .exc_valid_in(exc_valid_out),
        .exc_byte_in(exc_byte_out), .req_pass_in(req_pass_out), .req_valid_out(req_valid_in),
        .req_addr_out(req_addr_in), .req_func_out(req_func_in),
        .checks_out(checks));
    assign {func_known_in, addr_ok_in, value_ok_in} = checks;
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    function automatic logic [15:0] crc16(input logic [23:0] m);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < 3; i++) begin
            c = c ^ {8'h00, m[23 - 8 * i -: 8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    function automatic logic [15:0] tc(input logic [2:0] code);
        return code == 3'h0 ? 16'h0000 : 16'h00fa << (code - 3'h1);
    endfunction : tc
    task automatic expect_exc(input logic [7:0] a, input logic [7:0] f, input logic [7:0] code);
        logic [15:0] crc;
        crc = crc16({a, f | 8'h80, code});
        check("exception", u_ssx_host_model.exc_seen, 1'b1);
        check("echo addr", u_ssx_host_model.resp[0], a);
        check("echo func", u_ssx_host_model.resp[1], f | 8'h80);
        check("code", u_ssx_host_model.resp[2], code);
        check("crc", {u_ssx_host_model.resp[4], u_ssx_host_model.resp[3]}, crc);
    endtask : expect_exc
    task automatic pulse_setup();
        setup_write_command_in = 1'b1;
        @(negedge clock_in);
        setup_write_command_in = 1'b0;
        @(negedge clock_in);
    endtask : pulse_setup
    initial begin
        {setup_write_command_in, binary_protocol_address_enable_command_in, remote_restart_command_in,
            fallback_in, zero_trim_command_in, sample_valid_in, setup_byte1_in, setup_byte2_in,
            setup_byte3_in, setup_byte4_in, binary_address_in, zero_trim_value_in, sample_in} = '0;
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        check("text addr rst", text_channel_address_out, ssx_pkg::RST_TEXT_ADDR);
        check("bin addr rst", binary_address_out, ssx_pkg::RST_BIN_ADDR);
        check("reading rst", reading_out, 16'h8000);
        sys_rst_in = 1'b0;
        @(negedge clock_in);
        check("cal after reset", calibrating_out, 1'b1);
        for (int i = 0; i < 10; i++) begin
            b1 = (i == 9) ? 8'h7f : 8'h20 + 8'(i);
            p = 2'(i);
            c3 = 3'(i);
            {setup_byte1_in, setup_byte2_in} = {b1, c3[0], p, 1'b0, baud_code[i]};
            {setup_byte3_in, setup_byte4_in} = {6'h00, p, p, c3, c3 + 3'h1};
            pulse_setup();
            check("text addr", text_channel_address_out, b1);
            check("addr valid", text_address_valid_out, b1 >= 8'h21 && b1 <= 8'h7e);
            check("baud", baud_out, baud_rate[i]);
            check("parity", parity_out, p == 2'h1 ? ssx_pkg::PAR_EVEN :
                p == 2'h3 ? ssx_pkg::PAR_ODD : ssx_pkg::PAR_NONE);
            check("linefeed", linefeed_out, c3[0]);
            check("data bits", data_bits_out, ssx_pkg::TEXT_DATA_BITS);
            check("delay", delay_chars_out, {p, 1'b0});
            check("digits", digits_out, p);
            check("large tc", large_tc_ms_out, tc(c3));
            check("small tc", small_tc_ms_out, tc(c3 + 3'h1));
        end
        // Setup already done above, so the binary address comes second
        binary_address_in = 8'h5a;
        binary_protocol_address_enable_command_in = 1'b1;
        @(negedge clock_in);
        binary_protocol_address_enable_command_in = 1'b0;
        check("bin addr", binary_address_out, 8'h5a);
        check("text addr kept", text_channel_address_out, 8'h7f);
        remote_restart_command_in = 1'b1;
        @(negedge clock_in);
        remote_restart_command_in = 1'b0;
        check("binary mode", text_mode_out, 1'b0);
        u_ssx_host_model.send(8'h5a, 8'h04, 3'h7);
        expect_exc(8'h5a, 8'h04, ssx_pkg::EXC_BUSY);
        n = 10;
        while (calibrating_out !== 1'b0 && n < 100) begin
            @(negedge clock_in);
            n++;
        end
        check("cal length", n >= 17 && n <= 23, 1'b1);
        check("binary frame", data_bits_out, ssx_pkg::BIN_DATA_BITS);
        for (int i = 0; i < 4; i++) begin
            u_ssx_host_model.send(8'h5a, 8'h41 + 8'(i), oks[i]);
            expect_exc(8'h5a, 8'h41 + 8'(i), codes[i]);
        end
        u_ssx_host_model.send(8'h5a, 8'h04, 3'h7);
        check("pass", u_ssx_host_model.pass_seen, 1'b1);
        check("no exception", u_ssx_host_model.exc_seen, 1'b0);
        for (int i = 0; i < 5; i++) begin
            zero_trim_value_in = trims[i];
            sample_in = samples[i];
            zero_trim_command_in = 1'b1;
            @(negedge clock_in);
            // Trim lands one edge ahead so the sample is scaled with it
            {zero_trim_command_in, sample_valid_in} = 2'h1;
            @(negedge clock_in);
            sample_valid_in = 1'b0;
            n = 32'(samples[i] + trims[i]);
            repeat (8) @(negedge clock_in);
            check("reading", reading_out, n > 32766 ? ssx_pkg::READ_POS_OVERLOAD :
                n < -32767 ? ssx_pkg::READ_NEG_OVERLOAD : 16'(n + 32768));
        end
        fallback_in = 1'b1;
        @(negedge clock_in);
        check("fallback text", data_bits_out, ssx_pkg::TEXT_DATA_BITS);
        fallback_in = 1'b0;
        @(negedge clock_in);
        check("fallback cal", calibrating_out, 1'b1);
        complete_run();
    end
endmodule : serial_setup_exception_logic_tb_top
